// *** common/sre_pkg.sv ***
package sre_pkg;

	// ------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------
	localparam logic [7:0]  SRE_RAM_LAST      = 8'hDF;
	localparam logic [7:0]  SRE_CFG_ADDR      = 8'h90;
	localparam int          SRE_CFG_ERASE_BIT = 2;
	localparam logic [7:0]  SRE_CFG_RESET     = 8'h00;
	localparam logic [7:0]  SRE_NV_HI_FIRST   = 8'hF8;
	localparam logic [7:0]  SRE_NV_HI_LAST    = 8'hFB;
	localparam logic [5:0]  SRE_NV_TAG        = 6'h3E;
	localparam int          SRE_NV_PAGES      = 32;
	localparam int          SRE_PAGE_BYTES    = 32;
	localparam logic [7:0]  SRE_ERASED        = 8'hFF;

	// ------------------------------------------------------------
	// Command codes and protocol values
	// ------------------------------------------------------------
	localparam logic [7:0]  SRE_CMD_BLK_WR    = 8'hFC;
	localparam logic [7:0]  SRE_CMD_BLK_RD    = 8'hFD;
	localparam logic [7:0]  SRE_CMD_ERASE     = 8'hFE;
	localparam logic [4:0]  SRE_SLAVE_HI      = 5'h07;
	localparam logic [7:0]  SRE_BLK_COUNT     = 8'h20;
	localparam logic [8:0]  SRE_BLK_BYTES     = 9'h020;
	localparam logic [7:0]  SRE_CRC_POLY      = 8'h07;
	localparam logic [7:0]  SRE_IDLE_BYTE     = 8'hFF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SRE_CLK_MHZ       = 250;
	localparam int SRE_ERASE_TIME_MS = 20;
	localparam int SRE_PROG_TIME_US  = 250;
	localparam int SRE_TMO_TIME_MS   = 30;
	localparam int SRE_BOOT_TIME_MS  = 1;
	localparam int SRE_ERASE_CYC     = SRE_ERASE_TIME_MS * 1000 * SRE_CLK_MHZ;
	localparam int SRE_PROG_CYC      = SRE_PROG_TIME_US * SRE_CLK_MHZ;
	localparam int SRE_TMO_CYC       = SRE_TMO_TIME_MS * 1000 * SRE_CLK_MHZ;
	localparam int SRE_BOOT_CYC      = SRE_BOOT_TIME_MS * 1000 * SRE_CLK_MHZ;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic        isNv;
		logic [15:0] addr;
	} sre_ptr_t;

	typedef struct packed {
		logic selHi;
		logic selLo;
		logic sda;
		logic scl;
	} sre_pins_t;

	typedef enum logic [2:0] {
		SRE_M_IDLE = 3'h0,
		SRE_M_RX   = 3'h1,
		SRE_M_ACK  = 3'h3,
		SRE_M_TX   = 3'h2,
		SRE_M_MACK = 3'h6,
		SRE_M_WAIT = 3'h7
	} sre_mode_t;

endpackage

// *** hdl/sre_sync.sv ***
`timescale 1ns/10ps

module sre_sync #(
	parameter int W = 4
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] rawIn,
	output logic      [W-1:0] cleanOut
);
	logic [W-1:0] ff1Q;
	logic [W-1:0] ff2Q;
	logic [W-1:0] ff3Q;

	// ------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree
	// ------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				ff1Q[i]     <= 1'b1;
				ff2Q[i]     <= 1'b1;
				ff3Q[i]     <= 1'b1;
				cleanOut[i] <= 1'b1;
			end else begin
				ff1Q[i] <= rawIn[i];
				ff2Q[i] <= ff1Q[i];
				ff3Q[i] <= ff2Q[i];
				if (ff2Q[i] == ff3Q[i]) begin
					cleanOut[i] <= ff3Q[i];
				end
			end
		end
	end
endmodule

// *** hdl/sre_top.sv ***
`timescale 1ns/10ps

module sre_top import sre_pkg::*; #(
	parameter int unsigned ERASE_CYCLES = SRE_ERASE_CYC,
	parameter int unsigned PROG_CYCLES  = SRE_PROG_CYC,
	parameter int unsigned TMO_CYCLES   = SRE_TMO_CYC,
	parameter int unsigned BOOT_CYCLES  = SRE_BOOT_CYC
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic sclIn,
	output logic      sclOut,
	output logic      sclOe,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	input  wire logic addr_select_hi_pin,
	input  wire logic addr_select_lo_pin,
	output logic      nvBusy
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] ramMem [0:SRE_RAM_LAST];
	logic [7:0] nvMem  [0:SRE_NV_PAGES*SRE_PAGE_BYTES-1];

	sre_pins_t  pins;
	sre_mode_t  modeQ;
	sre_ptr_t   ptrQ;
	logic       sclPrevQ;
	logic       sdaPrevQ;
	logic [7:0] shQ;
	logic [3:0] bitCntQ;
	logic       pendQ;
	logic       dirReadQ;
	logic [8:0] idxQ;
	logic [8:0] txIdxQ;
	logic [7:0] cmdQ;
	logic [7:0] cntQ;
	logic       blkRdQ;
	logic [7:0] crcQ;
	logic [7:0] cfgQ;
	logic [31:0] eraseCntQ;
	logic [4:0]  erasePageQ;
	logic [5:0]  eraseStepQ;
	logic [31:0] progCntQ;
	logic [31:0] tmoCntQ;
	logic [31:0] bootCntQ;

	// ------------------------------------------------------------
	// Pin conditioning
	// ------------------------------------------------------------
	sre_sync #(
		.W(4)
	) u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.rawIn   ({addr_select_hi_pin, addr_select_lo_pin, sdaIn, sclIn}),
		.cleanOut(pins)
	);

	function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ SRE_CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Bus events
	// ------------------------------------------------------------
	wire sclRise  = pins.scl & ~sclPrevQ;
	wire sclFall  = ~pins.scl & sclPrevQ;
	wire startEv  = pins.scl & sclPrevQ & ~pins.sda & sdaPrevQ;
	wire stopEv   = pins.scl & sclPrevQ & pins.sda & ~sdaPrevQ;
	wire eraseBsy = (eraseCntQ != 32'h0);
	wire progBsy  = (progCntQ != 32'h0);
	// Stall ends one cycle early so the stretch never outlasts nvBusy
	wire progLong = (progCntQ > 32'h1);
	wire bootDone = (bootCntQ >= BOOT_CYCLES);
	wire tmoHit   = (tmoCntQ >= TMO_CYCLES);

	// ------------------------------------------------------------
	// Byte decode
	// ------------------------------------------------------------
	wire cmdRam   = (cmdQ <= SRE_RAM_LAST);
	wire cmdNv    = (cmdQ >= SRE_NV_HI_FIRST) && (cmdQ <= SRE_NV_HI_LAST);
	wire cmdBw    = (cmdQ == SRE_CMD_BLK_WR);
	wire [8:0] pecIdx = cmdRam ? 9'h003 : cmdNv ? 9'h004 : cmdBw ? 9'(9'h003 + cntQ) : 9'h002;
	wire isAddr   = (idxQ == 9'h000);
	wire isCmd    = (idxQ == 9'h001);
	wire isWr     = (cmdRam && idxQ == 9'h002) || (cmdNv && idxQ == 9'h003)
	                || (cmdBw && idxQ >= 9'h003 && idxQ < pecIdx);
	wire isPec    = (idxQ == pecIdx) && !isCmd && !isAddr;
	wire nvInRange = (ptrQ.addr[15:10] == SRE_NV_TAG);
	wire ramInRange = (ptrQ.addr[15:8] == 8'h00) && (ptrQ.addr[7:0] <= SRE_RAM_LAST);
	wire [9:0] nvIdx = ptrQ.addr[9:0];
	wire needStall = progLong && isWr && ptrQ.isNv;
	wire procEv   = pendQ && !pins.scl && !needStall;
	wire addrHit  = (shQ[7:1] == {SRE_SLAVE_HI, pins.selHi, pins.selLo});
	wire addrAck  = addrHit && !eraseBsy && bootDone;
	wire pecOk    = (shQ == crcQ);
	wire byteAck  = isAddr ? addrAck : isPec ? pecOk : (idxQ <= pecIdx);
	wire eraseGo  = isCmd && (shQ == SRE_CMD_ERASE) && cfgQ[SRE_CFG_ERASE_BIT]
	                && ptrQ.isNv && nvInRange;

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	wire [7:0] ramRd = (ptrQ.addr[7:0] == SRE_CFG_ADDR) ? cfgQ
	                 : ramInRange ? ramMem[ptrQ.addr[7:0]] : 8'h00;
	wire [7:0] memRd = ptrQ.isNv ? (nvInRange ? nvMem[nvIdx] : SRE_IDLE_BYTE) : ramRd;
	wire blkData    = blkRdQ && (txIdxQ != 9'h000) && (txIdxQ <= SRE_BLK_BYTES);
	wire [7:0] txNext = !blkRdQ ? ((txIdxQ == 9'h000) ? memRd : crcQ)
	                  : (txIdxQ == 9'h000) ? SRE_BLK_COUNT
	                  : blkData ? memRd
	                  : (txIdxQ == 9'(SRE_BLK_BYTES + 9'h001)) ? crcQ
	                  : SRE_IDLE_BYTE;
	wire nvProg = procEv && isWr && ptrQ.isNv && nvInRange && (nvMem[nvIdx] == SRE_ERASED);
	wire ramWr  = procEv && isWr && !ptrQ.isNv;

	// ------------------------------------------------------------
	// Nonvolatile array: page erase steps one byte per cycle
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (eraseBsy && !eraseStepQ[5]) begin
			nvMem[{erasePageQ, eraseStepQ[4:0]}] <= SRE_ERASED;
		end else if (nvProg) begin
			nvMem[nvIdx] <= shQ;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ramWr && ramInRange && ptrQ.addr[7:0] != SRE_CFG_ADDR) begin
			ramMem[ptrQ.addr[7:0]] <= shQ;
		end
	end

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			eraseCntQ  <= 32'h0;
			erasePageQ <= 5'h00;
			eraseStepQ <= 6'h00;
			progCntQ   <= 32'h0;
			bootCntQ   <= 32'h0;
		end else begin
			if (procEv && eraseGo && !eraseBsy) begin
				eraseCntQ  <= ERASE_CYCLES;
				erasePageQ <= ptrQ.addr[9:5];
				eraseStepQ <= 6'h00;
			end else if (eraseBsy) begin
				eraseCntQ  <= eraseCntQ - 32'h1;
				eraseStepQ <= eraseStepQ[5] ? eraseStepQ : eraseStepQ + 6'h01;
			end
			if (nvProg) begin
				progCntQ <= PROG_CYCLES;
			end else if (progBsy) begin
				progCntQ <= progCntQ - 32'h1;
			end
			if (!bootDone) begin
				bootCntQ <= bootCntQ + 32'h1;
			end
		end
	end

	// Stalls caused by our own clock stretching never count as a timeout
	always_ff @(posedge sys_clk) begin
		if (sys_rst || pins.scl || modeQ == SRE_M_IDLE || sclOe) begin
			tmoCntQ <= 32'h0;
		end else if (!tmoHit) begin
			tmoCntQ <= tmoCntQ + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Configuration and pointer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfgQ <= SRE_CFG_RESET;
		end else if (ramWr && ptrQ.addr[7:0] == SRE_CFG_ADDR && ramInRange) begin
			cfgQ <= shQ;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ptrQ <= '0;
		end else if (procEv && isCmd && shQ <= SRE_RAM_LAST) begin
			ptrQ <= '{isNv: 1'b0, addr: {8'h00, shQ}};
		end else if (procEv && cmdNv && idxQ == 9'h002) begin
			ptrQ <= '{isNv: 1'b1, addr: {cmdQ, shQ}};
		end else if ((procEv && isWr && cmdBw) || (modeQ == SRE_M_ACK && sclFall && dirReadQ
		             && blkData)) begin
			ptrQ.addr <= ptrQ.addr + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Transaction engine
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			modeQ    <= SRE_M_IDLE;
			sclPrevQ <= 1'b1;
			sdaPrevQ <= 1'b1;
			shQ      <= 8'h00;
			bitCntQ  <= 4'h0;
			pendQ    <= 1'b0;
			dirReadQ <= 1'b0;
			idxQ     <= 9'h000;
			txIdxQ   <= 9'h000;
			cmdQ     <= 8'h00;
			cntQ     <= 8'h00;
			blkRdQ   <= 1'b0;
			crcQ     <= 8'h00;
			sdaOe    <= 1'b0;
			sclOe    <= 1'b0;
		end else begin
			sclPrevQ <= pins.scl;
			sdaPrevQ <= pins.sda;
			// Stretch outlives the ack by a cycle, so SDA never moves with SCL high
			sclOe    <= pendQ && !pins.scl && (needStall || sclOe);
			if (stopEv || tmoHit) begin
				modeQ  <= SRE_M_IDLE;
				sdaOe  <= 1'b0;
				pendQ  <= 1'b0;
				blkRdQ <= 1'b0;
				crcQ   <= 8'h00;
			end else if (startEv) begin
				modeQ   <= SRE_M_RX;
				sdaOe   <= 1'b0;
				bitCntQ <= 4'h0;
				pendQ   <= 1'b0;
				idxQ    <= 9'h000;
			end else begin
				case (modeQ)
					SRE_M_RX: begin
						if (sclRise && !pendQ) begin
							shQ     <= {shQ[6:0], pins.sda};
							bitCntQ <= bitCntQ + 4'h1;
							pendQ   <= (bitCntQ == 4'h7);
						end else if (procEv) begin
							pendQ <= 1'b0;
							sdaOe <= byteAck;
							modeQ <= byteAck ? SRE_M_ACK : SRE_M_WAIT;
							crcQ  <= crcStep(crcQ, shQ);
							idxQ  <= (idxQ == 9'h1FF) ? idxQ : idxQ + 9'h001;
							if (isAddr) begin
								dirReadQ <= shQ[0];
								txIdxQ   <= 9'h000;
							end
							if (isCmd) begin
								cmdQ <= shQ;
								if (shQ == SRE_CMD_BLK_RD) begin
									blkRdQ <= 1'b1;
								end
							end
							if (cmdBw && idxQ == 9'h002) begin
								cntQ <= shQ;
							end
						end
					end
					SRE_M_ACK: begin
						if (sclFall) begin
							bitCntQ <= 4'h0;
							if (dirReadQ) begin
								sdaOe  <= ~txNext[7];
								shQ    <= {txNext[6:0], 1'b0};
								crcQ   <= crcStep(crcQ, txNext);
								txIdxQ <= txIdxQ + 9'h001;
								modeQ  <= SRE_M_TX;
							end else begin
								sdaOe <= 1'b0;
								modeQ <= SRE_M_RX;
							end
						end
					end
					SRE_M_TX: begin
						if (sclRise) begin
							bitCntQ <= bitCntQ + 4'h1;
						end else if (sclFall) begin
							if (bitCntQ == 4'h8) begin
								sdaOe <= 1'b0;
								modeQ <= SRE_M_MACK;
							end else begin
								sdaOe <= ~shQ[7];
								shQ   <= {shQ[6:0], 1'b0};
							end
						end
					end
					SRE_M_MACK: begin
						if (sclRise) begin
							modeQ <= pins.sda ? SRE_M_WAIT : SRE_M_ACK;
						end
					end
					// Any clock seen here releases SDA; flush clocks land here too
					SRE_M_WAIT: begin
						if (sclFall) begin
							sdaOe <= 1'b0;
						end
					end
					default: begin
						sdaOe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Open-drain drivers and status
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sdaOut <= 1'b0;
			sclOut <= 1'b0;
			nvBusy <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
			sclOut <= 1'b0;
			nvBusy <= eraseBsy || progBsy;
		end
	end
endmodule

// *** tb/sre_top_props.sv ***
`timescale 1ns/10ps

module sre_top_props import sre_pkg::*; #(
	parameter int unsigned ERASE_CYCLES = SRE_ERASE_CYC,
	parameter int unsigned PROG_CYCLES  = SRE_PROG_CYC,
	parameter int unsigned TMO_CYCLES   = SRE_TMO_CYC,
	parameter int unsigned BOOT_CYCLES  = SRE_BOOT_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sclIn,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic addr_select_hi_pin,
	input wire logic addr_select_lo_pin,
	input wire logic nvBusy
);
	// --------
	// Counters
	// --------
	// Busy time restarts at each stretch, so only an erase can run long
	logic [31:0] busyCnt_q, busyCnt_d;
	logic [31:0] holdCnt_q, holdCnt_d;
	logic [31:0] bootCnt_q, bootCnt_d;

	assign busyCnt_d = (nvBusy && !sclOe) ? busyCnt_q + 32'h1 : 32'h0;
	assign holdCnt_d = sclOe ? holdCnt_q + 32'h1 : 32'h0;
	assign bootCnt_d = (bootCnt_q < BOOT_CYCLES) ? bootCnt_q + 32'h1 : bootCnt_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busyCnt_q <= 32'h0;
			holdCnt_q <= 32'h0;
			bootCnt_q <= 32'h0;
		end else begin
			busyCnt_q <= busyCnt_d;
			holdCnt_q <= holdCnt_d;
			bootCnt_q <= bootCnt_d;
		end
	end

	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence ackHigh;
		sdaOe && $rose(sclIn);
	endsequence
	sequence ackHeld;
		sdaOe [*4];
	endsequence

	scl_open_drain_a: assert property (sclOut == 1'b0)
		else $error("SCL output not low");
	sda_open_drain_a: assert property (sdaOut == 1'b0)
		else $error("SDA output not low");
	rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> !sdaOe && !sclOe && !nvBusy)
		else $error("Outputs active after reset");
	sda_change_low_a: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("SDA changed while SCL high");
	ack_stands_a: assert property (ackHigh |-> ackHeld)
		else $error("SDA drive dropped in SCL high");
	stretch_busy_a: assert property (sclOe |-> nvBusy)
		else $error("SCL held low while idle");
	stretch_bound_a: assert property (holdCnt_q <= PROG_CYCLES + 8)
		else $error("SCL held low too long");
	erase_nack_a: assert property (busyCnt_q > PROG_CYCLES + 50 |-> !sdaOe)
		else $error("Access acked during erase");
	erase_bound_a: assert property (busyCnt_q <= ERASE_CYCLES + 4)
		else $error("Erase busy too long");
	boot_nack_a: assert property (bootCnt_q < BOOT_CYCLES |-> !sdaOe)
		else $error("Access acked during boot");
endmodule

bind sre_top sre_top_props #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES),
	.TMO_CYCLES(TMO_CYCLES), .BOOT_CYCLES(BOOT_CYCLES)) props (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_hi_pin(addr_select_hi_pin),
	.addr_select_lo_pin(addr_select_lo_pin), .nvBusy(nvBusy));

// *** tb/sre_master.sv ***
`timescale 1ns/10ps

module sre_master (
	input  wire logic sys_clk,
	input  wire logic sclLine,
	input  wire logic sdaLine,
	output logic      sclPull,
	output logic      sdaPull
);
	initial begin
		sclPull = 1'b0;
		sdaPull = 1'b0;
	end

	// ----------
	// Bit slots
	// ----------
	task automatic waitClk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// A released SCL is waited on, so a device stretch is honoured
	task automatic bitIo(input logic b, output logic s);
		sdaPull <= ~b;
		waitClk(10);
		sclPull <= 1'b0;
		for (int n = 0; n < 1000 && sclLine !== 1'b1; n++) @(posedge sys_clk);
		waitClk(20);
		s = sdaLine;
		sclPull <= 1'b1;
		waitClk(10);
	endtask

	task automatic start();
		sdaPull <= 1'b0;
		waitClk(10);
		sclPull <= 1'b0;
		waitClk(20);
		sdaPull <= 1'b1;
		waitClk(20);
		sclPull <= 1'b1;
		waitClk(10);
	endtask

	task automatic stop();
		sdaPull <= 1'b1;
		waitClk(10);
		sclPull <= 1'b0;
		waitClk(20);
		sdaPull <= 1'b0;
		waitClk(40);
	endtask

	task automatic wrByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitIo(b[i], s);
		bitIo(1'b1, s);
		ack = (s === 1'b0);
	endtask

	// Caller acks count and data, nacks the last byte before stop
	task automatic rdByte(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
		bitIo(~ackIt, s);
	endtask
endmodule

// *** tb/tb_sre_top.sv ***
`timescale 1ns/10ps

module tb_sre_top import sre_pkg::*;;
	localparam logic [7:0] DEV_W = {SRE_SLAVE_HI, 2'b10, 1'b0};
	localparam logic [7:0] DEV_R = DEV_W | 8'h01;
	localparam int         TMO_CYC = 2000;

	logic       sys_clk, sys_rst, selHi, selLo, ok;
	logic       sclOe, sdaOe, sclOut, sdaOut, nvBusy, mScl, mSda;
	logic       sclLine, sdaLine;
	logic       seenStretch;
	logic [7:0] rdVal, crcAcc, blkExp;
	int         errors, numChecks;

	// Wired-AND with pull-ups
	assign sclLine = ~(sclOe | mScl);
	assign sdaLine = ~(sdaOe | mSda);

	sre_top #(.ERASE_CYCLES(3000), .PROG_CYCLES(600), .TMO_CYCLES(TMO_CYC), .BOOT_CYCLES(1000)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_hi_pin(selHi),
		.addr_select_lo_pin(selLo), .nvBusy(nvBusy));
	sre_master m (.sys_clk(sys_clk), .sclLine(sclLine), .sdaLine(sdaLine),
		.sclPull(mScl), .sdaPull(mSda));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Sticky record that the device ever held SCL low
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			seenStretch <= 1'b0;
		end else if (sclOe) begin
			seenStretch <= 1'b1;
		end
	end

	// --------
	// Helpers
	// --------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ SRE_CRC_POLY : {r[6:0], 1'b0};
		return r;
	endfunction

	task automatic wr(input logic [7:0] q[$], output logic allAck);
		logic a;
		m.start();
		m.wrByte(DEV_W, allAck);
		foreach (q[i]) begin
			m.wrByte(q[i], a);
			allAck &= a;
		end
		m.stop();
	endtask

	task automatic rd(output logic [7:0] d);
		logic a;
		m.start();
		m.wrByte(DEV_R, a);
		m.rdByte(1'b0, d);
		m.stop();
	endtask

	task automatic rdNv(input logic [7:0] lo, output logic [7:0] d);
		wr({SRE_NV_HI_FIRST, lo}, ok);
		rd(d);
	endtask

	task automatic erasePage(input logic [7:0] lo);
		wr({SRE_NV_HI_FIRST, lo}, ok);
		wr({SRE_CMD_ERASE}, ok);
		check({7'h00, nvBusy}, 8'h01);
		repeat (400) @(posedge sys_clk);
		wr({SRE_CFG_ADDR}, ok);
		check({7'h00, ok}, 8'h00);
		for (int n = 0; n < 4000 && nvBusy !== 1'b0; n++) @(posedge sys_clk);
	endtask

	task automatic final_report();
		if (errors == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge sys_clk);
		errors++;
		final_report();
	end

	// ---------
	// Sequence
	// ---------
	initial begin
		sys_rst = 1'b1;
		selHi = 1'b1;
		selLo = 1'b0;
		errors = 0;
		numChecks = 0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wr({SRE_CFG_ADDR}, ok);
		check({7'h00, ok}, 8'h00);
		repeat (1000) @(posedge sys_clk);
		m.start();
		m.wrByte(8'h70, ok);
		m.stop();
		check({7'h00, ok}, 8'h00);
		wr({SRE_CFG_ADDR}, ok);
		rd(rdVal);
		check(rdVal, SRE_CFG_RESET);
		wr({8'h10, 8'hA5}, ok);
		wr({8'hDF, 8'h5A}, ok);
		check({7'h00, ok}, 8'h01);
		wr({8'h10}, ok);
		rd(rdVal);
		check(rdVal, 8'hA5);
		wr({8'hDF}, ok);
		rd(rdVal);
		check(rdVal, 8'h5A);
		wr({SRE_CFG_ADDR, 8'h00}, ok);
		wr({SRE_NV_HI_FIRST, 8'h3F}, ok);
		wr({SRE_CMD_ERASE}, ok);
		check({7'h00, nvBusy}, 8'h00);
		wr({SRE_CFG_ADDR, 8'h04}, ok);
		wr({SRE_CFG_ADDR}, ok);
		rd(rdVal);
		check(rdVal, 8'h04);
		erasePage(8'h3F);
		wr({SRE_NV_HI_FIRST, 8'h23, 8'h3C}, ok);
		check({7'h00, ok}, 8'h01);
		repeat (700) @(posedge sys_clk);
		rdNv(8'h23, rdVal);
		check(rdVal, 8'h3C);
		wr({SRE_NV_HI_FIRST, 8'h23, 8'h00}, ok);
		repeat (700) @(posedge sys_clk);
		rdNv(8'h23, rdVal);
		check(rdVal, 8'h3C);
		erasePage(8'h2A);
		rdNv(8'h23, rdVal);
		check(rdVal, SRE_ERASED);
		rdNv(8'h3F, rdVal);
		check(rdVal, SRE_ERASED);
		erasePage(8'h5F);
		wr({SRE_NV_HI_FIRST, 8'h40}, ok);
		wr({SRE_CMD_BLK_WR, 8'h03, 8'h11, 8'h22, 8'h33}, ok);
		check({7'h00, ok}, 8'h01);
		check({7'h00, seenStretch}, 8'h01);
		repeat (700) @(posedge sys_clk);
		wr({SRE_NV_HI_FIRST, 8'h40}, ok);
		m.start();
		m.wrByte(DEV_W, ok);
		m.wrByte(SRE_CMD_BLK_RD, ok);
		m.start();
		m.wrByte(DEV_R, ok);
		check({7'h00, ok}, 8'h01);
		crcAcc = crcStep(crcStep(crcStep(8'h00, DEV_W), SRE_CMD_BLK_RD), DEV_R);
		for (int i = 0; i < 33; i++) begin
			blkExp = (i == 0) ? SRE_BLK_COUNT : (i < 4) ? 8'(8'h11 * i) : SRE_ERASED;
			m.rdByte(1'b1, rdVal);
			check(rdVal, blkExp);
			crcAcc = crcStep(crcAcc, blkExp);
		end
		m.rdByte(1'b0, rdVal);
		m.stop();
		check(rdVal, crcAcc);
		crcAcc = crcStep(crcStep(crcStep(8'h00, DEV_W), 8'h12), 8'h77);
		wr({8'h12, 8'h77, crcAcc}, ok);
		check({7'h00, ok}, 8'h01);
		wr({8'h12, 8'h77, crcAcc ^ 8'h01}, ok);
		check({7'h00, ok}, 8'h00);
		// SCL parked low past the limit drops the transfer in progress
		m.start();
		m.wrByte(DEV_W, ok);
		check({7'h00, ok}, 8'h01);
		repeat (TMO_CYC + 100) @(posedge sys_clk);
		m.wrByte(8'h12, ok);
		m.stop();
		check({7'h00, ok}, 8'h00);
		final_report();
	end
endmodule
